// file: logic/clock_output_control_regs.sv
/*
 * Clock output control register bank: two-wire serial slave with byte and
 * block read/write, six control bytes, and the output gate they steer.
 * Assumes scl and sda_in synchronous to mclk and much slower than it;
 * the sda wire is resolved outside from sda_oe (drive low when high).
 */
// Function
// - byte 0 bits 7..1 enable link pairs 7..1 (pair 7 shared with debug port), 0 is high impedance, reset 1.
// - byte 1 bits 7, 5 and 4 enable free PCI clock 0, the USB clock and the reference output, reset 1.
// - byte 1 bit 6 enables the display pair, 0 is high impedance, reset 1.
// - byte 1 bits 2 and 1 enable processor pairs 1 and 0, 0 is high impedance, reset 1.
// - byte 1 bit 0 turns spread spectrum on, reset off.
// - byte 2 bits 7..2 enable PCI clocks 5..0 and bits 1, 0 free PCI clocks 2, 1, reset 1.
// - byte 3 bits 7..1 let the stop request halt link pairs 7..1, reset 0.
// - byte 4 bits 5..3 let the stop request halt free PCI clocks 2..0, reset 0.
// - byte 4 bit 6 puts the display pair in high impedance during power-down, reset 0.
// - byte 5 bit 7 puts halted link pairs in high impedance while stopped, reset 0.
// - byte 5 bit 3 puts link pairs in high impedance during power-down, reset 0.
// - byte 5 bits 1..0 put processor pairs 1..0, and bit 2 link pair 7, in high impedance during power-down, reset 0.
// - the device acknowledges address byte 8'hd2 (write) and its read form.
// - command bit 7 set selects a single byte at offset bits 6..0, clear selects a block from offset 0.
// - stoppable outputs halt and restart together at a clock boundary.
`timescale 1ns/1ps
module clock_output_control_regs
    import clock_output_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // two-wire serial bus
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // control inputs
    input  wire logic       soft_stop_request,
    input  wire logic       power_down_input,
    input  wire logic       stop_boundary,
    // output controls
    output logic [7:1]      link_pair_oe,
    output logic [7:1]      link_pair_run,
    output logic [1:0]      cpu_pair_oe,
    output logic            display_pair_oe,
    output logic [2:0]      free_pci_en,
    output logic [2:0]      free_pci_run,
    output logic [5:0]      pci_en,
    output logic            usb_en,
    output logic            ref_en,
    output logic            spread_en,
    output logic            clocks_run
);
    serial_state_t state_q;
    byte_role_t    role_q;
    logic [7:0]    shreg_q;
    logic [3:0]    bitcnt_q;
    logic [6:0]    ptr_q;
    logic          rw_q;
    logic          block_q;
    logic          count_sent_q;
    logic          mack_q;
    logic          scl_q;
    logic          sda_q;
    ctl_bank_t     ctl_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;
    logic          byte_in;
    logic          wr_en;
    logic [7:0]    rd_data;
    logic [7:0]    tx_next;

    ctl_bank_if bank ();

    assign bank.ctl = ctl_q;
    assign sda_out  = 1'b0;

    // line history for edge and condition detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    assign scl_rise  = scl & ~scl_q;
    assign scl_fall  = ~scl & scl_q;
    assign bus_start = scl & scl_q & sda_q & ~sda_in;
    assign bus_stop  = scl & scl_q & ~sda_q & sda_in;
    assign byte_in   = (state_q == st_rx) && scl_fall
                       && (bitcnt_q == BYTE_BITS);
    assign wr_en     = byte_in && (role_q == r_data) && !rw_q;

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (ptr_q == 7'(i))
                rd_data = ctl_q[i];
        end
    end

    // block reads send the byte count first
    assign tx_next = (block_q && !count_sent_q) ? BLOCK_COUNT : rd_data;

    // register bank, writes to unmapped offsets are dropped
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
        always_ff @(posedge mclk) begin
            if (rst)
                ctl_q[g] <= RST_BANK[g];
            else if (wr_en && ptr_q == 7'(g))
                ctl_q[g] <= shreg_q;
        end
    end

    // serial protocol engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q      <= st_idle;
            role_q       <= r_addr;
            shreg_q      <= 8'h00;
            bitcnt_q     <= 4'h0;
            ptr_q        <= 7'h00;
            rw_q         <= 1'b0;
            block_q      <= 1'b0;
            count_sent_q <= 1'b0;
            mack_q       <= 1'b0;
            sda_oe       <= 1'b0;
        end else if (bus_start) begin
            state_q  <= st_rx;
            role_q   <= r_addr;
            bitcnt_q <= 4'h0;
            sda_oe   <= 1'b0;
        end else if (bus_stop) begin
            state_q <= st_idle;
            sda_oe  <= 1'b0;
        end else begin
            unique case (state_q)
                st_idle: begin
                    sda_oe <= 1'b0;
                end
                st_rx: begin
                    if (scl_rise && bitcnt_q != BYTE_BITS) begin
                        shreg_q  <= {shreg_q[6:0], sda_in};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end else if (byte_in) begin
                        state_q  <= st_rx_ack;
                        bitcnt_q <= 4'h0;
                        unique case (role_q)
                            r_addr: begin
                                if (shreg_q[7:1] == DEV_ADDR_WR[7:1]) begin
                                    sda_oe <= 1'b1;
                                    rw_q   <= shreg_q[0];
                                end else begin
                                    state_q <= st_idle;
                                end
                            end
                            r_cmd: begin
                                sda_oe       <= 1'b1;
                                block_q      <= ~shreg_q[CMD_SINGLE];
                                ptr_q        <= shreg_q[CMD_SINGLE]
                                                ? shreg_q[6:0] : 7'h00;
                                count_sent_q <= 1'b0;
                            end
                            r_count: begin
                                sda_oe <= 1'b1;
                            end
                            r_data: begin
                                sda_oe <= 1'b1;
                                ptr_q  <= ptr_q + 7'h01;
                            end
                        endcase
                    end
                end
                st_rx_ack: begin
                    if (scl_fall) begin
                        if (role_q == r_addr && rw_q) begin
                            state_q  <= st_tx;
                            shreg_q  <= tx_next;
                            sda_oe   <= ~tx_next[7];
                            bitcnt_q <= 4'h1;
                            if (block_q && !count_sent_q)
                                count_sent_q <= 1'b1;
                            else
                                ptr_q <= ptr_q + 7'h01;
                        end else begin
                            state_q <= st_rx;
                            sda_oe  <= 1'b0;
                            unique case (role_q)
                                r_addr:  role_q <= r_cmd;
                                r_cmd:   role_q <= block_q ? r_count : r_data;
                                r_count: role_q <= r_data;
                                r_data:  role_q <= r_data;
                            endcase
                        end
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        if (bitcnt_q == BYTE_BITS) begin
                            state_q <= st_tx_ack;
                            sda_oe  <= 1'b0;
                        end else begin
                            sda_oe   <= ~shreg_q[6];
                            shreg_q  <= {shreg_q[6:0], 1'b0};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end
                    end
                end
                st_tx_ack: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_in;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            state_q  <= st_tx;
                            shreg_q  <= tx_next;
                            sda_oe   <= ~tx_next[7];
                            bitcnt_q <= 4'h1;
                            if (block_q && !count_sent_q)
                                count_sent_q <= 1'b1;
                            else
                                ptr_q <= ptr_q + 7'h01;
                        end else begin
                            state_q <= st_idle;
                        end
                    end
                end
            endcase
        end
    end

    clock_output_gate u_gate (
        .mclk              (mclk),
        .rst               (rst),
        .soft_stop_request (soft_stop_request),
        .power_down_input  (power_down_input),
        .stop_boundary     (stop_boundary),
        .bank              (bank.dst),
        .link_pair_oe      (link_pair_oe),
        .link_pair_run     (link_pair_run),
        .cpu_pair_oe       (cpu_pair_oe),
        .display_pair_oe   (display_pair_oe),
        .free_pci_en       (free_pci_en),
        .free_pci_run      (free_pci_run),
        .pci_en            (pci_en),
        .usb_en            (usb_en),
        .ref_en            (ref_en),
        .spread_en         (spread_en),
        .clocks_run        (clocks_run)
    );

endmodule : clock_output_control_regs

// file: logic/clock_output_gate.sv
/*
 * Output gate: turns the control bytes, the stop request and power-down
 * into per-output enable and run levels.
 * Assumes inputs synchronous to mclk and stop_boundary pulsing once per
 * slowest stoppable clock period at a low phase.
 */
`timescale 1ns/1ps
module clock_output_gate
    import clock_output_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // controls
    input  wire logic       soft_stop_request,
    input  wire logic       power_down_input,
    input  wire logic       stop_boundary,
    ctl_bank_if.dst         bank,
    // output controls
    output logic [7:1]      link_pair_oe,
    output logic [7:1]      link_pair_run,
    output logic [1:0]      cpu_pair_oe,
    output logic            display_pair_oe,
    output logic [2:0]      free_pci_en,
    output logic [2:0]      free_pci_run,
    output logic [5:0]      pci_en,
    output logic            usb_en,
    output logic            ref_en,
    output logic            spread_en,
    output logic            clocks_run
);
    logic       stop_active_q;
    logic       power_down_state;
    logic [7:1] link_halt;
    logic [2:0] fpci_halt;
    logic [7:1] link_hiz;

    // stop taken only at a clock boundary, so no short pulses
    always_ff @(posedge mclk) begin
        if (rst)
            stop_active_q <= 1'b0;
        else if (stop_boundary)
            stop_active_q <= soft_stop_request;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            power_down_state <= 1'b0;
        else
            power_down_state <= power_down_input;
    end

    assign link_halt = {7{stop_active_q}}
        & bank.ctl[OFS_LINK_STOP][LINK_STOP_HI:LINK_STOP_LO];
    assign fpci_halt = {3{stop_active_q}}
        & bank.ctl[OFS_FPCI_STOP][FPCI_STOP_HI:FPCI_STOP_LO];
    assign link_hiz = (link_halt
        & {7{bank.ctl[OFS_DRIVE_MODES][LINK_STOP_HIZ]}})
        | {7{power_down_state
             & bank.ctl[OFS_DRIVE_MODES][LINK_PD_HIZ]}}
        | {power_down_state
           & bank.ctl[OFS_DRIVE_MODES][CPU2_PD_HIZ], 6'h00};

    always_ff @(posedge mclk) begin
        if (rst) begin
            link_pair_oe    <= RST_LINK_EN[LINK_EN_HI:LINK_EN_LO];
            link_pair_run   <= 7'h7f;
            cpu_pair_oe     <= 2'h3;
            display_pair_oe <= 1'b1;
            free_pci_en     <= 3'h7;
            free_pci_run    <= 3'h7;
            pci_en          <= 6'h3f;
            usb_en          <= 1'b1;
            ref_en          <= 1'b1;
            spread_en       <= 1'b0;
            clocks_run      <= 1'b1;
        end else begin
            link_pair_oe    <= bank.ctl[OFS_LINK_EN][LINK_EN_HI:LINK_EN_LO]
                               & ~link_hiz;
            link_pair_run   <= ~link_halt & {7{~power_down_state}};
            cpu_pair_oe[1]  <= bank.ctl[OFS_MISC_EN][CPU1_EN]
                & ~(power_down_state
                    & bank.ctl[OFS_DRIVE_MODES][CPU1_PD_HIZ]);
            cpu_pair_oe[0]  <= bank.ctl[OFS_MISC_EN][CPU0_EN]
                & ~(power_down_state
                    & bank.ctl[OFS_DRIVE_MODES][CPU0_PD_HIZ]);
            display_pair_oe <= bank.ctl[OFS_MISC_EN][DISPLAY_EN]
                & ~(power_down_state
                    & bank.ctl[OFS_FPCI_STOP][DISPLAY_PD_HIZ]);
            free_pci_en     <= {bank.ctl[OFS_PCI_EN][FPCI2_EN],
                                bank.ctl[OFS_PCI_EN][FPCI1_EN],
                                bank.ctl[OFS_MISC_EN][FPCI0_EN]};
            free_pci_run    <= ~fpci_halt & {3{~power_down_state}};
            pci_en          <= bank.ctl[OFS_PCI_EN][PCI_EN_HI:PCI_EN_LO];
            usb_en          <= bank.ctl[OFS_MISC_EN][USB_EN];
            ref_en          <= bank.ctl[OFS_MISC_EN][REF_EN];
            spread_en       <= bank.ctl[OFS_MISC_EN][SPREAD_EN];
            clocks_run      <= ~power_down_state;
        end
    end

endmodule : clock_output_gate

// file: logic/clock_output_pkg.sv
/*
 * Constants and types for the clock output control register bank:
 * register offsets, reset values, field positions, serial protocol codes.
 * Assumes nothing of its surroundings.
 */
package clock_output_pkg;

    // register offsets (index within the bank)
    localparam int REG_COUNT       = 6;
    localparam int OFS_LINK_EN     = 0;
    localparam int OFS_MISC_EN     = 1;
    localparam int OFS_PCI_EN      = 2;
    localparam int OFS_LINK_STOP   = 3;
    localparam int OFS_FPCI_STOP   = 4;
    localparam int OFS_DRIVE_MODES = 5;

    // power-up values
    localparam logic [7:0] RST_LINK_EN     = 8'hff;
    localparam logic [7:0] RST_MISC_EN     = 8'hf6;
    localparam logic [7:0] RST_PCI_EN      = 8'hff;
    localparam logic [7:0] RST_LINK_STOP   = 8'h00;
    localparam logic [7:0] RST_FPCI_STOP   = 8'h07;
    localparam logic [7:0] RST_DRIVE_MODES = 8'h00;

    typedef logic [7:0] ctl_bank_t [REG_COUNT];

    localparam ctl_bank_t RST_BANK = '{RST_LINK_EN, RST_MISC_EN, RST_PCI_EN,
                                       RST_LINK_STOP, RST_FPCI_STOP,
                                       RST_DRIVE_MODES};

    // field positions
    localparam int LINK_EN_HI      = 7;
    localparam int LINK_EN_LO      = 1;
    localparam int FPCI0_EN        = 7;
    localparam int DISPLAY_EN      = 6;
    localparam int USB_EN          = 5;
    localparam int REF_EN          = 4;
    localparam int CPU1_EN         = 2;
    localparam int CPU0_EN         = 1;
    localparam int SPREAD_EN       = 0;
    localparam int PCI_EN_HI       = 7;
    localparam int PCI_EN_LO       = 2;
    localparam int FPCI2_EN        = 1;
    localparam int FPCI1_EN        = 0;
    localparam int LINK_STOP_HI    = 7;
    localparam int LINK_STOP_LO    = 1;
    localparam int DISPLAY_PD_HIZ  = 6;
    localparam int FPCI_STOP_HI    = 5;
    localparam int FPCI_STOP_LO    = 3;
    localparam int LINK_STOP_HIZ   = 7;
    localparam int LINK_PD_HIZ     = 3;
    localparam int CPU2_PD_HIZ     = 2;
    localparam int CPU1_PD_HIZ     = 1;
    localparam int CPU0_PD_HIZ     = 0;

    // serial protocol
    localparam logic [7:0] DEV_ADDR_WR = 8'hd2;
    localparam int         CMD_SINGLE  = 7;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [7:0] BLOCK_COUNT = 8'h06;

    typedef enum {st_idle, st_rx, st_rx_ack, st_tx, st_tx_ack} serial_state_t;
    typedef enum {r_addr, r_cmd, r_count, r_data} byte_role_t;

endpackage : clock_output_pkg

// file: logic/ctl_bank_if.sv
/*
 * Carries the six control bytes from the register bank to the output gate.
 * Assumes the bank drives it and the gate only reads it.
 */
`timescale 1ns/1ps
interface ctl_bank_if;
    import clock_output_pkg::*;
    ctl_bank_t ctl;
    modport src (output ctl);
    modport dst (input ctl);
endinterface : ctl_bank_if

// file: verif/clock_output_control_regs_asserts.sv
/* Checker for the clock output control register bank, on its top ports.
   Assumes one mclk domain; bound to the design below. */
`timescale 1ns/1ps
module clock_output_control_regs_asserts (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // serial bus
    input wire logic       scl,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // gate
    input wire logic       power_down_input,
    input wire logic       stop_boundary,
    input wire logic [7:1] link_pair_oe,
    input wire logic [7:1] link_pair_run,
    input wire logic [2:0] free_pci_run,
    input wire logic [5:0] pci_en,
    input wire logic       clocks_run
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // recent power-down and boundary history
    logic [3:0] pd_h_q;
    logic [2:0] bnd_h_q;
    logic       pd_moved;
    always_ff @(posedge mclk) begin
        pd_h_q  <= {pd_h_q[2:0], power_down_input};
        bnd_h_q <= {bnd_h_q[1:0], stop_boundary};
    end
    assign pd_moved = |(pd_h_q ^ {pd_h_q[2:0], power_down_input});
    sequence s_pd_on; power_down_input [*4]; endsequence
    sequence s_pd_off; !power_down_input [*4]; endsequence
    property p_reset_vals;
        disable iff (1'b0) rst |=> link_pair_oe == 7'h7f
            && link_pair_run == 7'h7f && pci_en == 6'h3f && !sda_oe;
    endproperty
    property p_run_cause;
        $changed(link_pair_run) |-> bnd_h_q[1] || bnd_h_q[2] || pd_moved;
    endproperty
    property p_pd_halts;
        s_pd_on |-> link_pair_run == 7'h00 && free_pci_run == 3'h0
            && !clocks_run;
    endproperty
    property p_pd_release; s_pd_off |-> clocks_run; endproperty
    property p_ack_edge;
        $changed(sda_oe) |-> !$past(scl) && ($past(scl, 2) || $past(scl, 3));
    endproperty
    property p_oe_steady; scl && $past(scl) |-> $stable(sda_oe); endproperty
    property p_open_drain; sda_oe |-> !sda_out; endproperty
    property p_en_low_scl; $changed(pci_en) |-> !scl && !$past(scl); endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not at power-up values");
    a_run_cause: assert property (p_run_cause)
        else $error("link run changed away from a boundary");
    a_pd_halts: assert property (p_pd_halts)
        else $error("clocks running in power-down");
    a_pd_release: assert property (p_pd_release)
        else $error("clocks stopped without power-down");
    a_ack_edge: assert property (p_ack_edge)
        else $error("sda drive moved away from an scl fall");
    a_oe_steady: assert property (p_oe_steady)
        else $error("sda drive moved while scl high");
    a_open_drain: assert property (p_open_drain)
        else $error("sda driven high");
    a_en_low_scl: assert property (p_en_low_scl)
        else $error("pci enables moved while scl high");
endmodule : clock_output_control_regs_asserts

bind clock_output_control_regs clock_output_control_regs_asserts chk (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_down_input(power_down_input), .stop_boundary(stop_boundary),
    .link_pair_oe(link_pair_oe), .link_pair_run(link_pair_run),
    .free_pci_run(free_pci_run), .pci_en(pci_en), .clocks_run(clocks_run));

// file: verif/clock_output_control_regs_test.sv
/* Self-checking bench for the clock output control register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module clock_output_control_regs_test
    import clock_output_pkg::*;
;
    localparam ctl_bank_t RESV = '{8'h01, 8'h08, 8'h00, 8'h01, 8'h87, 8'h70};
    logic        mclk, rst, scl, sda_low, sda_oe, sda_out, res_v;
    logic        stop_req, pd, crun, usb, refo, spr, d_oe;
    logic        bnd = 1'b0, stopped_m = 1'b0, snap_v = 1'b0;
    logic [2:0]  bcnt = 3'h0, f_en, f_run;
    logic [7:0]  res, q[$];
    logic [7:1]  l_oe, l_run;
    logic [1:0]  c_oe;
    logic [5:0]  p_en;
    logic [32:0] outs, exp_v, act_v, exp_q[$];
    ctl_bank_t   bank_m;
    int          fail_count = 0, tests_run = 0, cycles = 0, seed = 63;
    wire         sda = !(sda_low | sda_oe);
    assign outs = {l_oe, l_run, c_oe, d_oe, f_en, f_run, p_en, usb, refo,
                   spr, crun};
    clock_output_control_regs uut (
        .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .soft_stop_request(stop_req),
        .power_down_input(pd), .stop_boundary(bnd), .link_pair_oe(l_oe),
        .link_pair_run(l_run), .cpu_pair_oe(c_oe), .display_pair_oe(d_oe),
        .free_pci_en(f_en), .free_pci_run(f_run), .pci_en(p_en),
        .usb_en(usb), .ref_en(refo), .spread_en(spr), .clocks_run(crun));
    two_wire_host host (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_low(sda_low), .res_v(res_v), .res(res));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic finish_test();
        if (exp_q.size() != 0)
            fail_count++;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    // boundary pulses, stop model and timeout
    always @(posedge mclk) begin
        bcnt <= bcnt + 3'h1;
        bnd <= (bcnt == 3'h7);
        if (bnd)
            stopped_m <= stop_req;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            finish_test();
        end
    end
    // result monitor
    always @(posedge mclk) begin
        if (snap_v || res_v) begin
            act_v = snap_v ? outs : {25'h0, res};
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            tests_run++;
            if (act_v !== exp_v) begin
                $display("wrong value at %0t: got %h expected %h", $time,
                         act_v, exp_v);
                fail_count++;
            end
        end
    end
    function automatic logic [32:0] expect_outs();
        logic [7:0] b0, b1, b2, b3, b4, b5;
        logic [7:1] halt, loe;
        {b0, b1, b2, b3, b4, b5} = {bank_m[0], bank_m[1], bank_m[2],
                                    bank_m[3], bank_m[4], bank_m[5]};
        halt = {7{stopped_m}} & b3[7:1];
        loe = b0[7:1] & ~(halt & {7{b5[7]}}) & ~{7{pd & b5[3]}};
        loe[7] = loe[7] & !(pd & b5[2]);
        return {loe, ~halt & {7{!pd}}, b1[2:1] & ~({2{pd}} & b5[1:0]),
                b1[6] & !(pd & b4[6]), b2[1:0], b1[7],
                ~({3{stopped_m}} & b4[5:3]) & {3{!pd}}, b2[7:2],
                b1[5], b1[4], b1[0], !pd};
    endfunction : expect_outs
    function automatic logic [7:0] legal(input int ofs, input logic [7:0] r);
        return (r & ~RESV[ofs]) | (RST_BANK[ofs] & RESV[ofs]);
    endfunction : legal
    task automatic check_outs();
        exp_q.push_back(expect_outs());
        snap_v <= 1'b1;
        @(posedge mclk);
        snap_v <= 1'b0;
    endtask : check_outs
    task automatic ack_n(input int n, input logic a);
        repeat (n) exp_q.push_back({32'h0, a});
    endtask : ack_n
    task automatic wr_byte(input logic [6:0] ofs, input logic [7:0] v);
        ack_n(3, 1'b1);
        host.write_seq(DEV_ADDR_WR, {1'b1, ofs}, '{v});
        if (ofs < 7'h06)
            bank_m[ofs] = v;
        repeat (4) @(posedge mclk);
        check_outs();
    endtask : wr_byte
    task automatic rd_byte(input logic [6:0] ofs);
        ack_n(3, 1'b1);
        exp_q.push_back(ofs < 7'h06 ? {25'h0, bank_m[ofs]} : 33'h0);
        host.read_seq({1'b1, ofs}, 1);
    endtask : rd_byte
    task automatic rd_block(input int n);
        ack_n(3, 1'b1);
        exp_q.push_back({25'h0, BLOCK_COUNT});
        for (int i = 0; i < n - 1; i++) exp_q.push_back({25'h0, bank_m[i]});
        host.read_seq(8'h00, n);
    endtask : rd_block
    initial begin
        rst = 1'b1;
        stop_req = 1'b0;
        pd = 1'b0;
        bank_m = RST_BANK;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        check_outs();
        rd_block(7);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 6; i++) begin
                wr_byte(7'(i), legal(i, 8'($random(seed))));
                rd_byte(7'(i));
            end
        end
        wr_byte(7'h06, 8'h5a);
        rd_byte(7'h06);
        rd_byte(7'h7f);
        ack_n(3, 1'b0);
        host.write_seq(8'ha4, 8'h80, '{8'h00});
        rd_byte(7'h00);
        q = '{BLOCK_COUNT};
        for (int i = 0; i < 6; i++) q.push_back(legal(i, 8'($random(seed))));
        ack_n(9, 1'b1);
        host.write_seq(DEV_ADDR_WR, 8'h00, q);
        for (int i = 0; i < 6; i++) bank_m[i] = q[i + 1];
        rd_block(3);
        rd_block(7);
        wr_byte(7'h03, 8'hfe);
        wr_byte(7'h04, 8'h3f);
        wr_byte(7'h05, 8'h80);
        for (int s = 1; s >= 0; s--) begin
            @(posedge mclk iff bnd);
            stop_req <= s[0];
            repeat (2) @(posedge mclk);
            check_outs();
            @(posedge mclk iff bnd);
            repeat (4) @(posedge mclk);
            check_outs();
        end
        wr_byte(7'h04, 8'h7f);
        foreach (q[i]) begin
            wr_byte(7'h05, i == 0 ? 8'h0f : 8'h00);
            pd <= 1'b1;
            repeat (6) @(posedge mclk);
            check_outs();
            pd <= 1'b0;
            repeat (6) @(posedge mclk);
            check_outs();
            if (i == 1)
                break;
        end
        repeat (10) @(posedge mclk);
        finish_test();
    end
endmodule : clock_output_control_regs_test

// file: verif/two_wire_host.sv
/* Host controller model for the two-wire serial bus.
   Assumes sda pulled up and resolved by the bench from both drivers. */
`timescale 1ns/1ps
module two_wire_host
    import clock_output_pkg::*;
(
    // clock and wire
    input  wire logic  mclk,
    input  wire logic  sda,
    output logic       scl = 1'b1,
    output logic       sda_low = 1'b0,
    // results to the bench
    output logic       res_v = 1'b0,
    output logic [7:0] res = 8'h00
);
    task automatic put_bit(input logic b);
        scl <= 1'b0;
        repeat (2) @(posedge mclk);
        sda_low <= !b;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : put_bit
    task automatic get_bit(output logic b);
        scl <= 1'b0;
        sda_low <= 1'b0;
        repeat (4) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        b = sda;
        repeat (2) @(posedge mclk);
    endtask : get_bit
    task automatic emit(input logic [7:0] v);
        res <= v;
        res_v <= 1'b1;
        @(posedge mclk);
        res_v <= 1'b0;
    endtask : emit
    // start when stp is 0, stop when 1
    task automatic cond(input logic stp);
        scl <= 1'b0;
        repeat (2) @(posedge mclk);
        sda_low <= stp;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_low <= !stp;
        repeat (4) @(posedge mclk);
    endtask : cond
    task automatic send(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        emit({7'h00, !a});
    endtask : send
    task automatic fetch(input logic last);
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        emit(v);
        put_bit(last);
    endtask : fetch
    task automatic write_seq(input logic [7:0] adr, input logic [7:0] cmd,
                             input logic [7:0] d[$]);
        cond(1'b0);
        send(adr);
        send(cmd);
        foreach (d[i]) send(d[i]);
        cond(1'b1);
    endtask : write_seq
    task automatic read_seq(input logic [7:0] cmd, input int n);
        cond(1'b0);
        send(DEV_ADDR_WR);
        send(cmd);
        cond(1'b0);
        send(DEV_ADDR_WR | 8'h01);
        for (int i = 0; i < n; i++) fetch(i == n - 1);
        cond(1'b1);
    endtask : read_seq
endmodule : two_wire_host
